/* verilog/bsos_top.sv */
// boot strap order select: latches straps at reset release, decodes
// crystal, aux clock enable and boot order, and walks the order
// assumes strap pins are synchronous to clk_i and held during reset
//
// How it works
// - sample straps leaving reset, select order
// - bits 15:14 give crystal frequency
// - bits 13:12 must be zero, 11:6 ignored
// - bit 5 enables the aux clock output
// - code 11100b: flash, card, serial, device bus
// - code 11000b: spi, card, device bus, serial
// - failed source falls through to next
//
// Design decisions made here: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
module bsos_top
    import bsos_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [15:0] boot_strap_pins_i,
    input  wire logic        src_fail_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic [1:0]       xtal_sel_o,
    output logic             aux_clock_output_en_o,
    output logic [2:0]       boot_src_o,
    output logic             boot_exhausted_o,
    output logic             strap_valid_o
);

    // ==========================================================
    // strap capture
    logic [15:0] strap_q;
    logic        rst_seen_q;
    logic        captured_q;

    // capture on the first cycle after reset drops; straps then frozen
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rst_seen_q <= 1'b1;
            captured_q <= 1'b0;
            strap_q    <= STRAP_RST;
        end
        else if (rst_seen_q)
        begin
            rst_seen_q <= 1'b0;
            captured_q <= 1'b1;
            strap_q    <= boot_strap_pins_i;
        end
    end

    // ==========================================================
    // decode
    logic [4:0] order_code;
    logic       rsvd_bad;

    assign order_code = strap_q[ORDER_HI:ORDER_LO];
    // reserved field only flagged; 11:6 never looked at
    assign rsvd_bad   = strap_q[RSVD_HI:RSVD_LO] != RSVD_REQUIRED;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            xtal_sel_o            <= BSOS_XTAL_19M2;
            aux_clock_output_en_o <= 1'b0;
        end
        else
        begin
            xtal_sel_o            <= strap_q[XTAL_HI:XTAL_LO];
            aux_clock_output_en_o <= captured_q & strap_q[AUXCLK_BIT];
        end
    end

    // ==========================================================
    // order walk
    logic [1:0] slot_q;
    logic       exhaust_q;
    logic       fail_req;
    logic       restart_req;
    bsos_src_e  cur_src;
    logic       order_ok;

    bsos_order_rom bsos_order_rom_inst
    (
        .order_i (order_code),
        .slot_i  (slot_q),
        .src_o   (cur_src),
        .valid_o (order_ok)
    );

    // a failed source moves to the next slot; after the last, exhausted
    always_ff @(posedge clk_i)
    begin
        if (rst_i || restart_req)
        begin
            slot_q    <= 2'd0;
            exhaust_q <= 1'b0;
        end
        else if (fail_req && captured_q && !exhaust_q)
        begin
            if (slot_q == 2'd3)
                exhaust_q <= 1'b1;
            else
                slot_q <= slot_q + 2'd1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            boot_src_o       <= BSOS_SRC_NONE;
            boot_exhausted_o <= 1'b0;
            strap_valid_o    <= 1'b0;
        end
        else
        begin
            boot_src_o       <= (captured_q && !exhaust_q) ? cur_src : BSOS_SRC_NONE;
            boot_exhausted_o <= exhaust_q;
            strap_valid_o    <= captured_q & order_ok & ~rsvd_bad;
        end
    end

    // ==========================================================
    // wishbone slave, one wait state then ack
    logic req;
    logic wr;

    assign req         = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // write lands on the edge where the master sees ack, request still held
    assign wr          = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i
                       & (wb_adr_i == REG_CONTROL) & wb_sel_i[0];
    assign fail_req    = src_fail_i | (wr & wb_dat_i[CT_FAIL]);
    assign restart_req = wr & wb_dat_i[CT_RESTART];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= req;
            wb_dat_o <= 32'h0000_0000;
            if (req && !wb_we_i)
            begin
                unique case (wb_adr_i)
                    REG_STRAP:  wb_dat_o <= {16'h0000, strap_q};
                    REG_STATUS:
                    begin
                        wb_dat_o[ST_XTAL_LO +: 2] <= strap_q[XTAL_HI:XTAL_LO];
                        wb_dat_o[ST_AUX]          <= strap_q[AUXCLK_BIT];
                        wb_dat_o[ST_RSVD_BAD]     <= rsvd_bad;
                        wb_dat_o[ST_ORDER_BAD]    <= ~order_ok;
                        wb_dat_o[ST_EXHAUST]      <= exhaust_q;
                        wb_dat_o[ST_SLOT_LO +: 2] <= slot_q;
                        wb_dat_o[ST_SRC_LO +: 3]  <= cur_src;
                    end
                    REG_SOURCE: wb_dat_o <= {29'h0, cur_src};
                    default:    wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ==========================================================
    // checks
    property p_capture;
        @(posedge clk_i) $fell(rst_i) |=> (strap_q == $past(boot_strap_pins_i));
    endproperty
    a_capture: assert property (p_capture) else $error("strap not captured");

    property p_hold;
        @(posedge clk_i) disable iff (rst_i)
        (captured_q && $past(captured_q)) |-> $stable(strap_q);
    endproperty
    a_hold: assert property (p_hold) else $error("strap changed");

    property p_xtal;
        @(posedge clk_i) disable iff (rst_i)
        captured_q |=> (xtal_sel_o == $past(strap_q[XTAL_HI:XTAL_LO]));
    endproperty
    a_xtal: assert property (p_xtal) else $error("crystal decode wrong");

    property p_aux;
        @(posedge clk_i) disable iff (rst_i)
        captured_q |=> (aux_clock_output_en_o == $past(strap_q[AUXCLK_BIT]));
    endproperty
    a_aux: assert property (p_aux) else $error("aux clock enable wrong");

    property p_rsvd;
        @(posedge clk_i) disable iff (rst_i)
        (captured_q && strap_q[RSVD_HI:RSVD_LO] != RSVD_REQUIRED) |=> !strap_valid_o;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved code accepted");

    property p_first_default;
        @(posedge clk_i) disable iff (rst_i)
        (captured_q && order_code == ORDER_DEFAULT && slot_q == 2'h0 && !exhaust_q)
        |=> (boot_src_o == BSOS_SRC_FLASH);
    endproperty
    a_first_default: assert property (p_first_default) else $error("default first");

    property p_first_alt;
        @(posedge clk_i) disable iff (rst_i)
        (captured_q && order_code == ORDER_ALTERNATE && slot_q == 2'h0 && !exhaust_q)
        |=> (boot_src_o == BSOS_SRC_SPI);
    endproperty
    a_first_alt: assert property (p_first_alt) else $error("alternate first");

    sequence s_fail;
        captured_q && !exhaust_q && fail_req && !restart_req && slot_q != 2'd3;
    endsequence
    property p_fall;
        @(posedge clk_i) disable iff (rst_i)
        s_fail |=> (slot_q == $past(slot_q) + 2'd1);
    endproperty
    a_fall: assert property (p_fall) else $error("no fall through");

endmodule

/* verilog/bsos_pkg.sv */
// package for the boot strap order select block
// assumes one 50 MHz clock and a synchronous active-high reset
package bsos_pkg;

    // ==========================================================
    // strap field positions
    localparam int STRAP_W          = 16;
    localparam int XTAL_HI          = 15;
    localparam int XTAL_LO          = 14;
    localparam int RSVD_HI          = 13;
    localparam int RSVD_LO          = 12;
    localparam int AUXCLK_BIT       = 5;
    localparam int ORDER_HI         = 4;
    localparam int ORDER_LO         = 0;

    // ==========================================================
    // order codes and reset values
    localparam logic [4:0]  ORDER_DEFAULT   = 5'h1C;
    localparam logic [4:0]  ORDER_ALTERNATE = 5'h18;
    localparam logic [1:0]  RSVD_REQUIRED   = 2'h0;
    localparam logic [15:0] STRAP_RST       = 16'h0000;

    // ==========================================================
    // wishbone register offsets (byte addresses)
    localparam logic [3:0] REG_STRAP   = 4'h0;
    localparam logic [3:0] REG_STATUS  = 4'h4;
    localparam logic [3:0] REG_CONTROL = 4'h8;
    localparam logic [3:0] REG_SOURCE  = 4'hC;

    // status fields
    localparam int ST_XTAL_LO   = 0;
    localparam int ST_AUX       = 2;
    localparam int ST_RSVD_BAD  = 3;
    localparam int ST_ORDER_BAD = 4;
    localparam int ST_EXHAUST   = 5;
    localparam int ST_SLOT_LO   = 8;
    localparam int ST_SRC_LO    = 12;

    // control fields: write 1 to give up on current source, or restart
    localparam int CT_FAIL    = 0;
    localparam int CT_RESTART = 1;

    // ==========================================================
    // boot sources
    typedef enum logic [2:0]
    {
        BSOS_SRC_NONE  = 3'b000,
        BSOS_SRC_FLASH = 3'b001,
        BSOS_SRC_CARD  = 3'b010,
        BSOS_SRC_SER0  = 3'b011,
        BSOS_SRC_DEVB  = 3'b100,
        BSOS_SRC_SPI   = 3'b101
    } bsos_src_e;

    // crystal codes
    typedef enum logic [1:0]
    {
        BSOS_XTAL_19M2 = 2'b00,
        BSOS_XTAL_24M  = 2'b01,
        BSOS_XTAL_25M  = 2'b10,
        BSOS_XTAL_26M  = 2'b11
    } bsos_xtal_e;

endpackage

/* verilog/bsos_order_rom.sv */
// ordered source table for the boot order selector
// assumes the order code is already latched and stable
`timescale 1ns/1ps
module bsos_order_rom
    import bsos_pkg::*;
(
    input  wire logic [4:0] order_i,
    input  wire logic [1:0] slot_i,
    output bsos_src_e       src_o,
    output logic            valid_o
);

    // ==========================================================
    // table lookup, unknown codes give no source
    always_comb
    begin
        src_o   = BSOS_SRC_NONE;
        valid_o = 1'b1;
        if (order_i == ORDER_DEFAULT)
        begin
            unique case (slot_i)
                2'd0: src_o = BSOS_SRC_FLASH;
                2'd1: src_o = BSOS_SRC_CARD;
                2'd2: src_o = BSOS_SRC_SER0;
                2'd3: src_o = BSOS_SRC_DEVB;
            endcase
        end
        else if (order_i == ORDER_ALTERNATE)
        begin
            unique case (slot_i)
                2'd0: src_o = BSOS_SRC_SPI;
                2'd1: src_o = BSOS_SRC_CARD;
                2'd2: src_o = BSOS_SRC_DEVB;
                2'd3: src_o = BSOS_SRC_SER0;
            endcase
        end
        else
        begin
            valid_o = 1'b0;
        end
    end

endmodule

/* tb/bsos_strap_net.sv */
// strap network model: pull resistors, select button, header drivers
// assumes the header drivers see the board reset, active low
`timescale 1ns/1ps
module bsos_strap_net
(
    input  wire logic        board_reset_n_i,
    input  wire logic        button_i,
    input  wire logic        hdr_en_i,
    input  wire logic [15:0] hdr_val_i,
    output logic [15:0]      pins_o
);
    // ============================================================
    // resistor pattern, reserved pair pulled low
    localparam logic [15:0] PULL = 16'h401C;

    // button pulls one bit low; headers let go once reset lifts
    always_comb
    begin
        pins_o = PULL & ~{13'h0, button_i, 2'h0};
        if (hdr_en_i && !board_reset_n_i)
            pins_o = hdr_val_i;
    end
endmodule

/* tb/bsos_top_bench.sv */
// self-checking bench for the boot strap order select block
// assumes the 50 MHz clock and a wishbone answer of a few cycles
`timescale 1ns/1ps
module bsos_top_bench;
    import bsos_pkg::*;
    typedef struct packed
    {
        logic [15:0] pins;
        logic        hdr;
        logic        btn;
        logic [1:0]  xtal;
        logic        aux;
        logic [2:0]  src;
        logic        ok;
    } bsos_row_s;
    logic        clk_i, rst_i, brd_n, btn, hdr_en, src_fail, cyc, stb, we;
    logic        ack, aux, exh, vld;
    logic [3:0]  adr, sel;
    logic [15:0] hdr_val, pins;
    logic [31:0] dat_w, dat_r, q;
    logic [1:0]  xtal;
    logic [2:0]  src;
    int          miscompares, n_checks, k, j;
    // src 7 means the source is not looked at
    bsos_row_s rows [8] = '{
        '{16'h001C, 1'h1, 1'h0, 2'h0, 1'h0, 3'h1, 1'h1},
        '{16'h4038, 1'h1, 1'h0, 2'h1, 1'h1, 3'h5, 1'h1},
        '{16'h8FDC, 1'h1, 1'h0, 2'h2, 1'h0, 3'h1, 1'h1},
        '{16'hC03C, 1'h1, 1'h0, 2'h3, 1'h1, 3'h1, 1'h1},
        '{16'h101C, 1'h1, 1'h0, 2'h0, 1'h0, 3'h7, 1'h0},
        '{16'h0013, 1'h1, 1'h0, 2'h0, 1'h0, 3'h0, 1'h0},
        '{16'h401C, 1'h0, 1'h0, 2'h1, 1'h0, 3'h1, 1'h1},
        '{16'h4018, 1'h0, 1'h1, 2'h1, 1'h0, 3'h5, 1'h1}};
    logic [2:0] seq [2][3] = '{'{3'h2, 3'h3, 3'h4}, '{3'h2, 3'h4, 3'h3}};

    // ============================================================
    // design and strap network
    bsos_strap_net bsos_strap_net_inst (.board_reset_n_i(brd_n), .button_i(btn),
        .hdr_en_i(hdr_en), .hdr_val_i(hdr_val), .pins_o(pins));
    bsos_top bsos_top_inst (.clk_i(clk_i), .rst_i(rst_i), .boot_strap_pins_i(pins),
        .src_fail_i(src_fail), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
        .wb_ack_o(ack), .xtal_sel_o(xtal), .aux_clock_output_en_o(aux),
        .boot_src_o(src), .boot_exhausted_o(exh), .strap_valid_o(vld));

    // ============================================================
    // helpers
    task automatic final_report();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one classic cycle, entered just after a rising edge
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int i;
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        dat_w <= d;
        for (i = 0; i < 20; i++)
        begin
            @(posedge clk_i);
            if (ack === 1'h1)
                break;
        end
        q = dat_r;
        cyc <= 1'h0;
        stb <= 1'h0;
        if (i == 20)
        begin
            miscompares++;
            final_report();
        end
        @(posedge clk_i);
    endtask

    // headers release two edges late, after the capture edge
    task automatic boot(input bsos_row_s r);
        hdr_val <= r.pins;
        hdr_en <= r.hdr;
        btn <= r.btn;
        rst_i <= 1'h1;
        brd_n <= 1'h0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'h0;
        repeat (2) @(posedge clk_i);
        brd_n <= 1'h1;
        @(posedge clk_i);
    endtask

    initial
    begin
        clk_i = 1'h0;
        forever #10 clk_i = ~clk_i;
    end

    // ============================================================
    // main sequence
    initial
    begin
        {rst_i, brd_n, btn, hdr_en, src_fail, cyc, stb, we} <= 8'h80;
        adr <= 4'h0;
        sel <= 4'hF;
        hdr_val <= 16'h0000;
        dat_w <= 32'h0;
        repeat (3) @(negedge clk_i);
        chk({xtal, aux, src, exh, vld, ack}, 32'h0);
        $display("reset test done");
        // later stimulus starts just after a rising edge
        @(posedge clk_i);
        for (k = 0; k < 8; k++)
        begin
            boot(rows[k]);
            // both passes see released pins, outputs must hold
            for (j = 0; j < 2; j++)
            begin
                @(negedge clk_i);
                chk(xtal, rows[k].xtal);
                chk(aux, rows[k].aux);
                if (rows[k].src != 3'h7) chk(src, rows[k].src);
                chk(vld, rows[k].ok);
                @(posedge clk_i);
                // first pass reads the latched pins, second the current source
                wb(1'h0, (j == 0) ? REG_STRAP : REG_SOURCE, 32'h0);
                if (j == 0) chk(q, {16'h0, rows[k].pins});
                else if (rows[k].src != 3'h7) chk(q, {29'h0, rows[k].src});
            end
            $display("row %0d done", k);
        end
        // fall through: pin fails on default, register fails on alternate
        for (k = 0; k < 2; k++)
        begin
            boot(rows[6 + k]);
            for (j = 0; j < 4; j++)
            begin
                if (k == 0)
                begin
                    src_fail <= 1'h1;
                    @(posedge clk_i);
                    src_fail <= 1'h0;
                    repeat (2) @(posedge clk_i);
                end
                else
                    wb(1'h1, REG_CONTROL, 32'h1);
                @(negedge clk_i);
                chk(src, (j < 3) ? seq[k][j] : 3'h0);
                @(posedge clk_i);
            end
            chk(exh, 1'h1);
            wb(1'h0, REG_STATUS, 32'h0);
            chk(q[ST_EXHAUST], 1'h1);
            chk(q[ST_SLOT_LO +: 2], 2'h3);
            $display("fall through %0d done", k);
        end
        wb(1'h1, REG_STRAP, 32'hFFFF);
        wb(1'h0, REG_STRAP, 32'h0);
        chk(q, 32'h4018);
        wb(1'h0, 4'h2, 32'h0);
        chk(q, 32'h0);
        wb(1'h1, REG_CONTROL, 32'h2);
        @(posedge clk_i);
        @(negedge clk_i);
        chk({exh, src}, 4'h5);
        $display("register test done");
        final_report();
    end
endmodule
